/* shared/pei_consts.svh */
// Offsets, field positions, reset values and limits of the PHY extended control and interrupt block
`ifndef PEI_CONSTS_SVH
`define PEI_CONSTS_SVH

`define PEI_IDX_CTRL2        8'h18
`define PEI_IDX_MASK         8'h19
`define PEI_IDX_STATUS       8'h1a
`define PEI_ADDR_LSB         2
`define PEI_ADDR_W           12

`define PEI_EDGE_HI          15
`define PEI_EDGE_LO          13
`define PEI_SGIN_HI          8
`define PEI_SGIN_LO          7
`define PEI_SGOUT_BIT        6
`define PEI_JUMBO_HI         5
`define PEI_JUMBO_LO         4
`define PEI_AMP_HI           3
`define PEI_AMP_LO           1
`define PEI_LOOP_BIT         0

`define PEI_EDGE_RST         3'h6
`define PEI_SGIN_RST         2'h0
`define PEI_JUMBO_RST        2'h0
`define PEI_AMP_RST          3'h0

`define PEI_PIN_EN_BIT       15
`define PEI_SUMMARY_BIT      15
`define PEI_EV_SPEED         14
`define PEI_EV_LINK          13
`define PEI_EV_DUPLEX        12
`define PEI_EV_AN_ERR        11
`define PEI_EV_AN_DONE       10
`define PEI_EV_PD_DET        9
`define PEI_EV_MEDIA         4
`define PEI_EV_DOWNSHIFT     2
`define PEI_EV_MS_ERR        1
`define PEI_EV_IMPL          16'h7e16
`define PEI_MASK_IMPL        16'hfe16
`define PEI_MASK_SOFT_KEEP   16'hf616
`define PEI_ADV_ALL          4'hf

`define PEI_LEN_STD          15'h0600
`define PEI_LEN_9K           15'h2400
`define PEI_LEN_12K          15'h3000
`define PEI_LEN_16K          15'h4000
`define PEI_PPM_100          2'h0
`define PEI_PPM_70           2'h1
`define PEI_PPM_60           2'h2

`endif

/* shared/pei_pkg.sv */
// Types shared by the PHY extended control and interrupt block
package pei_pkg;

	typedef enum logic [1:0] {
		PEI_JUMBO_STD = 2'b00,
		PEI_JUMBO_9K  = 2'b01,
		PEI_JUMBO_12K = 2'b10,
		PEI_JUMBO_RSV = 2'b11
	} pei_jumbo_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pei_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pei_apb_rsp_t;

	typedef struct packed {
		logic [2:0] edge_rate;
		logic [1:0] sgmii_in_preamble;
		logic       sgmii_out_preamble;
		pei_jumbo_t jumbo_mode;
		logic [2:0] tx_amplitude;
		logic       connector_loopback;
	} pei_ctrl_t;

	typedef struct packed {
		logic speed_change;
		logic link_change;
		logic full_duplex_change;
		logic an_error;
		logic an_complete;
		logic pd_detect;
		logic media_change;
		logic downshift;
		logic ms_error;
	} pei_events_t;

endpackage : pei_pkg

/* src/pei_event_gate.sv */
// Qualifies raw event pulses into status set requests in the status layout
`include "pei_consts.svh"
module pei_event_gate (
	input  wire pei_pkg::pei_events_t events,
	input  wire logic                 an_enable,
	input  wire logic [3:0]           adv_bits,
	input  wire logic [15:0]          mask,
	output logic [15:0]               set_req
);
	import pei_pkg::*;

	logic [15:0] raw;

	always_comb begin
		raw = 16'h0000;
		raw[`PEI_EV_SPEED]     = events.speed_change & an_enable;
		raw[`PEI_EV_LINK]      = events.link_change;
		raw[`PEI_EV_DUPLEX]    = events.full_duplex_change & an_enable;
		raw[`PEI_EV_AN_ERR]    = events.an_error;
		raw[`PEI_EV_AN_DONE]   = events.an_complete;
		raw[`PEI_EV_PD_DET]    = events.pd_detect;
		raw[`PEI_EV_MEDIA]     = events.media_change;
		raw[`PEI_EV_DOWNSHIFT] = events.downshift & (adv_bits == `PEI_ADV_ALL);
		raw[`PEI_EV_MS_ERR]    = events.ms_error;
		set_req = raw & mask & `PEI_EV_IMPL;
	end

endmodule : pei_event_gate

/* src/pei_status_bank.sv */
// Sticky interrupt status bits with summary, read-to-clear and write-one-to-clear
`include "pei_consts.svh"
module pei_status_bank (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [15:0] set_req,
	input  wire logic        read_clear,
	input  wire logic [15:0] w1c,
	output logic [15:0]      status,
	output logic [15:0]      next_status
);
	import pei_pkg::*;

	logic [15:0] clr;
	logic [15:0] kept;

	always_comb begin
		clr  = read_clear ? 16'hffff : w1c;
		kept = ((status & ~clr) | set_req) & `PEI_EV_IMPL;                // Set wins over clear
		next_status = kept;
		next_status[`PEI_SUMMARY_BIT] = |kept;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			status <= 16'h0000;
		end else begin
			status <= next_status;
		end
	end

endmodule : pei_status_bank

/* src/pei_ext_ctrl_irq.sv */
// Extended control two, interrupt mask and interrupt status registers behind APB
//
// Functional notes
// - Edge-rate trim at bits 15:13, reset 110, codes 011 slowest to 100 fastest.
// - SGMII input preamble need at bits 8:7, reset 00; 11 reserved.
// - SGMII output preamble bit 6, reset 0; 1 sends two-byte preamble.
// - Jumbo mode bits 5:4, reset 00: standard, 9 KB, 12 KB, reserved.
// - Jumbo limits assume 100 ppm clock; 60 ppm gives larger limits in both modes, 70 ppm only in 12 KB mode.
// - Transmit amplitude trim at bits 3:1, reset 000 nominal.
// - Connector loopback enable at bit 0, reset 0.
// - Mask bits 14,13,12,11,10,9,4,2,1 read-write, reset 0, one enables event.
// - With mask bit 15 set, interrupt pin follows summary status bit 15.
// - Clearing mask bit 15 only blocks the pin; status keeps working.
// - Reading the status register clears all its set bits.
// - Status bit 15 summarises pending events; software reads 14:0 for cause.
// - Speed and duplex change events need auto-negotiation enable.
// - Downshift event needs all four advertisement bits set.
// - Status positions: 13,11,10,9,4,2,1 plus 14,12; one means pending.
`include "pei_consts.svh"
module pei_ext_ctrl_irq (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 soft_reset,
	input  wire pei_pkg::pei_apb_req_t apb_req,
	output pei_pkg::pei_apb_rsp_t     apb_rsp,
	input  wire pei_pkg::pei_events_t events,
	input  wire logic                 an_enable,
	input  wire logic [3:0]           adv_bits,
	input  wire logic [1:0]           ref_ppm_tier,
	output pei_pkg::pei_ctrl_t        ctrl,
	output logic [14:0]               jumbo_max_len,
	output logic                      irq,
	output logic                      interrupt_output_pin_out,
	output logic                      interrupt_output_pin_oe
);
	import pei_pkg::*;

	logic [15:0] mask;
	logic [15:0] set_req;
	logic [15:0] status;
	logic [15:0] next_status;
	logic [15:0] w1c;
	logic        read_clear;
	logic        setup;
	logic        access;
	logic        wr_ctrl;
	logic        wr_mask;
	logic        wr_status;
	logic [15:0] rd_word;
	logic        rd_err;
	logic [14:0] next_len;

	function automatic logic [9:0] reg_index(input logic [11:0] addr);
		reg_index = addr[11:`PEI_ADDR_LSB];
	endfunction : reg_index

	function automatic logic is_reg(input logic [11:0] addr, input logic [7:0] idx);
		is_reg = (reg_index(addr) == {2'b00, idx}) && (addr[1:0] == 2'b00);
	endfunction : is_reg

	function automatic logic [15:0] ctrl_word(input pei_ctrl_t c);
		ctrl_word = 16'h0000;
		ctrl_word[`PEI_EDGE_HI:`PEI_EDGE_LO] = c.edge_rate;
		ctrl_word[`PEI_SGIN_HI:`PEI_SGIN_LO] = c.sgmii_in_preamble;
		ctrl_word[`PEI_SGOUT_BIT]            = c.sgmii_out_preamble;
		ctrl_word[`PEI_JUMBO_HI:`PEI_JUMBO_LO] = c.jumbo_mode;
		ctrl_word[`PEI_AMP_HI:`PEI_AMP_LO]   = c.tx_amplitude;
		ctrl_word[`PEI_LOOP_BIT]             = c.connector_loopback;
	endfunction : ctrl_word

	// APB phases; the answer comes in the first access cycle
	assign setup  = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable & apb_rsp.pready;

	assign wr_ctrl   = access & apb_req.pwrite & is_reg(apb_req.paddr, `PEI_IDX_CTRL2);
	assign wr_mask   = access & apb_req.pwrite & is_reg(apb_req.paddr, `PEI_IDX_MASK);
	assign wr_status = access & apb_req.pwrite & is_reg(apb_req.paddr, `PEI_IDX_STATUS);
	assign read_clear = access & ~apb_req.pwrite & is_reg(apb_req.paddr, `PEI_IDX_STATUS);
	assign w1c = wr_status ? (apb_req.pwdata[15:0] & `PEI_EV_IMPL) : 16'h0000;

	// Read data and error decode
	always_comb begin
		rd_word = 16'h0000;
		rd_err  = 1'b0;
		if (is_reg(apb_req.paddr, `PEI_IDX_CTRL2)) begin
			rd_word = ctrl_word(ctrl);
		end else if (is_reg(apb_req.paddr, `PEI_IDX_MASK)) begin
			rd_word = mask & `PEI_MASK_IMPL;
		end else if (is_reg(apb_req.paddr, `PEI_IDX_STATUS)) begin
			rd_word = status;
		end else begin
			rd_err = 1'b1;
		end
	end

	// Bus answer registered at setup, held through the access cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			apb_rsp <= '0;
		end else if (setup) begin
			apb_rsp.pready  <= 1'b1;
			apb_rsp.pslverr <= rd_err;
			apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
		end else begin
			apb_rsp <= '0;
		end
	end

	// Edge rate, preambles and jumbo are sticky; amplitude and loopback are not
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl.edge_rate          <= `PEI_EDGE_RST;
			ctrl.sgmii_in_preamble  <= `PEI_SGIN_RST;
			ctrl.sgmii_out_preamble <= 1'b0;
			ctrl.jumbo_mode         <= pei_jumbo_t'(`PEI_JUMBO_RST);
		end else if (wr_ctrl) begin
			ctrl.edge_rate          <= apb_req.pwdata[`PEI_EDGE_HI:`PEI_EDGE_LO];
			ctrl.sgmii_in_preamble  <= apb_req.pwdata[`PEI_SGIN_HI:`PEI_SGIN_LO];
			ctrl.sgmii_out_preamble <= apb_req.pwdata[`PEI_SGOUT_BIT];
			ctrl.jumbo_mode <= pei_jumbo_t'(apb_req.pwdata[`PEI_JUMBO_HI:`PEI_JUMBO_LO]);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || soft_reset) begin
			ctrl.tx_amplitude       <= `PEI_AMP_RST;
			ctrl.connector_loopback <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl.tx_amplitude       <= apb_req.pwdata[`PEI_AMP_HI:`PEI_AMP_LO];
			ctrl.connector_loopback <= apb_req.pwdata[`PEI_LOOP_BIT];
		end
	end

	// Mask register; the auto-negotiation error mask (bit 11) is the only non-sticky bit
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mask <= 16'h0000;
		end else if (wr_mask) begin
			mask <= apb_req.pwdata[15:0] & `PEI_MASK_IMPL;
		end else if (soft_reset) begin
			mask <= mask & `PEI_MASK_SOFT_KEEP;
		end
	end

	// Jumbo length limit from mode and reference clock quality
	always_comb begin
		case (ctrl.jumbo_mode)
			PEI_JUMBO_9K: begin
				next_len = (ref_ppm_tier == `PEI_PPM_60) ? `PEI_LEN_12K : `PEI_LEN_9K;
			end
			PEI_JUMBO_12K: begin
				next_len = (ref_ppm_tier == `PEI_PPM_100) ? `PEI_LEN_12K : `PEI_LEN_16K;
			end
			default: begin
				next_len = `PEI_LEN_STD;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			jumbo_max_len <= `PEI_LEN_STD;
		end else begin
			jumbo_max_len <= next_len;
		end
	end

	pei_event_gate pei_event_gate_inst (
		.events    (events),
		.an_enable (an_enable),
		.adv_bits  (adv_bits),
		.mask      (mask),
		.set_req   (set_req)
	);

	pei_status_bank pei_status_bank_inst (
		.clk         (clk),
		.rst_b       (rst_b),
		.set_req     (set_req),
		.read_clear  (read_clear),
		.w1c         (w1c),
		.status      (status),
		.next_status (next_status)
	);

	// Interrupt line follows pending unmasked status regardless of pin enable
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & mask & `PEI_EV_IMPL);
		end
	end

	// Open-drain pin: pulled low while enabled and summary pending
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			interrupt_output_pin_out <= 1'b0;
			interrupt_output_pin_oe  <= 1'b0;
		end else begin
			interrupt_output_pin_out <= 1'b0;
			interrupt_output_pin_oe  <= mask[`PEI_PIN_EN_BIT]
				& next_status[`PEI_SUMMARY_BIT];
		end
	end

endmodule : pei_ext_ctrl_irq

/* bench/pei_ext_ctrl_irq_properties.sv */
// Port checks for the extended control and interrupt block
module pei_ext_ctrl_irq_properties (
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  soft_reset,
	input wire pei_pkg::pei_apb_req_t apb_req,
	input wire pei_pkg::pei_apb_rsp_t apb_rsp,
	input wire pei_pkg::pei_events_t  events,
	input wire logic                  an_enable,
	input wire logic [3:0]            adv_bits,
	input wire logic [1:0]            ref_ppm_tier,
	input wire pei_pkg::pei_ctrl_t    ctrl,
	input wire logic [14:0]           jumbo_max_len,
	input wire logic                  irq,
	input wire logic                  interrupt_output_pin_out,
	input wire logic                  interrupt_output_pin_oe
);
	import pei_pkg::*;
	logic rd_stat;
	logic quiet;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	assign rd_stat = apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == 12'h068;
	assign quiet = !irq && !apb_req.psel;
	chk_setup_answer: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no answer after setup");
	chk_ready_single: assert property ($rose(apb_rsp.pready) |=> !apb_rsp.pready)
		else $error("pready held too long");
	chk_unmapped_err: assert property (apb_req.psel && apb_req.paddr == 12'h06c && !apb_req.penable
		|=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped not refused");
	chk_ctrl_reset: assert property ($rose(rst_b) |-> ctrl.edge_rate == 3'h6 &&
		ctrl.tx_amplitude == 3'h0 && !ctrl.connector_loopback) else $error("bad control reset");
	chk_jumbo_std: assert property (ctrl.jumbo_mode == PEI_JUMBO_STD [*3] |->
		jumbo_max_len == 15'h0600) else $error("bad standard length");
	chk_jumbo_base: assert property ((ctrl.jumbo_mode == PEI_JUMBO_9K && ref_ppm_tier == 2'h0) [*3]
		|-> jumbo_max_len == 15'h2400) else $error("bad jumbo length");
	chk_pin_gated: assert property (interrupt_output_pin_oe |-> !interrupt_output_pin_out &&
		(irq || $past(interrupt_output_pin_oe)
		|| $past(apb_req.psel && apb_req.penable && apb_req.pwrite)))
		else $error("pin without interrupt");
	chk_read_clears: assert property (rd_stat && events == '0 |=> !irq && !interrupt_output_pin_oe)
		else $error("status read left interrupt");
	chk_speed_gate: assert property (quiet && !an_enable && (events & 9'h0bf) == 9'h0 |=> !irq)
		else $error("speed event without autoneg");
	chk_shift_gate: assert property (quiet && adv_bits != 4'hf && (events & 9'h1fd) == 9'h0 |=> !irq)
		else $error("downshift without advert");
endmodule : pei_ext_ctrl_irq_properties

bind pei_ext_ctrl_irq pei_ext_ctrl_irq_properties pei_ext_ctrl_irq_properties_inst (
	.clk, .rst_b, .soft_reset, .apb_req, .apb_rsp, .events, .an_enable, .adv_bits,
	.ref_ppm_tier, .ctrl, .jumbo_max_len, .irq, .interrupt_output_pin_out,
	.interrupt_output_pin_oe);

/* bench/tb_pei_ext_ctrl_irq.sv */
// Self-checking bench for the extended control and interrupt block
`include "pei_consts.svh"
module tb_pei_ext_ctrl_irq;
	timeunit 1ns;
	timeprecision 1ps;
	import pei_pkg::*;
	localparam logic [11:0] A_CTRL = {2'h0, `PEI_IDX_CTRL2, 2'h0};
	localparam logic [11:0] A_MASK = {2'h0, `PEI_IDX_MASK, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, `PEI_IDX_STATUS, 2'h0};
	logic         clk = 0;
	logic         rst_b = 0;
	logic         soft_reset = 0;
	pei_apb_req_t req = '0;
	pei_apb_rsp_t rsp;
	pei_events_t  events = '0;
	logic         an_enable = 1;
	logic [3:0]   adv_bits = 4'hf;
	logic [1:0]   ref_ppm_tier = 2'h0;
	pei_ctrl_t    ctrl;
	logic [14:0]  jumbo_max_len;
	logic         irq, pin_out, pin_oe, err;
	logic [15:0]  q;
	int           n_mismatch = 0, check_count = 0, cyc = 0;

	pei_ext_ctrl_irq pei_ext_ctrl_irq_inst (
		.clk, .rst_b, .soft_reset, .apb_req(req), .apb_rsp(rsp), .events, .an_enable,
		.adv_bits, .ref_ppm_tier, .ctrl, .jumbo_max_len, .irq,
		.interrupt_output_pin_out(pin_out), .interrupt_output_pin_oe(pin_oe));

	initial forever #5 clk = ~clk;

	task automatic test_done;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready, read data lands in q
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, {16'h0, d}};
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		while (rsp.pready !== 1'b1)
			@(posedge clk);
		q = rsp.prdata[15:0];
		err = rsp.pslverr;
		req <= '0;
	endtask : apb

	// One-cycle event pulse, returns once the flags have settled
	task automatic ev(input pei_events_t e);
		@(posedge clk);
		events <= e;
		@(posedge clk);
		events <= '0;
		@(posedge clk);
		#1;
	endtask : ev

	task automatic t_reset;
		apb(0, A_CTRL, 0);
		chk(q, 16'hc000);
		apb(0, A_MASK, 0);
		chk(q, 0);
		apb(0, A_STAT, 0);
		chk({q, irq, pin_oe, pin_out}, 0);
		chk(jumbo_max_len, 15'h0600);
	endtask : t_reset

	task automatic t_ctrl;
		apb(1, A_CTRL, 16'hffff);
		apb(0, A_CTRL, 0);
		chk(q, 16'he1ff);
		apb(1, A_CTRL, 16'h6128);
		apb(0, A_CTRL, 0);
		chk(q, 16'h6128);
		chk(ctrl, {3'b011, 2'b10, 1'b0, 2'b10, 3'b100, 1'b0});
		for (int m = 0; m < 4; m++)
			for (int t = 0; t < 3; t++) begin
				ref_ppm_tier <= 2'(t);
				apb(1, A_CTRL, 16'(m << 4));
				repeat (3) @(posedge clk);
				chk(jumbo_max_len, m == 1 ? (t == 2 ? 15'h3000 : 15'h2400) :
					m == 2 ? (t > 0 ? 15'h4000 : 15'h3000) : 15'h0600);
			end
	endtask : t_ctrl

	task automatic t_irq;
		int pos[9] = '{14, 13, 12, 11, 10, 9, 4, 2, 1};
		apb(1, A_MASK, 16'hffff);
		apb(0, A_MASK, 0);
		chk(q, 16'hfe16);
		for (int i = 0; i < 9; i++) begin
			ev(pei_events_t'(9'h100 >> i));
			chk({irq, pin_oe}, 2'b11);
			apb(0, A_STAT, 0);
			chk(q, 16'h8000 | (16'h1 << pos[i]));
			apb(0, A_STAT, 0);
			chk({q, irq, pin_oe}, 0);
		end
	endtask : t_irq

	task automatic t_gate;
		apb(1, A_MASK, 16'h7e16);
		ev(pei_events_t'(9'h080));
		chk({irq, pin_oe}, 2'b10);
		apb(1, A_STAT, 16'h2000);
		@(posedge clk);
		chk(irq, 0);
		apb(1, A_MASK, 16'h7e06);
		an_enable <= 0;
		adv_bits <= 4'h7;
		ev(pei_events_t'(9'h140));
		chk(irq, 0);
		ev(pei_events_t'(9'h002));
		chk(irq, 0);
		ev(pei_events_t'(9'h147));
		apb(0, A_STAT, 0);
		chk(q, 16'h8002);
		an_enable <= 1;
		adv_bits <= 4'hf;
	endtask : t_gate

	task automatic t_soft;
		apb(1, A_CTRL, 16'hffff);
		apb(1, A_MASK, 16'hfe16);
		@(posedge clk);
		soft_reset <= 1;
		@(posedge clk);
		soft_reset <= 0;
		apb(0, A_CTRL, 0);
		chk(q, 16'he1f0);
		apb(0, A_MASK, 0);
		chk(q, 16'hf616);
		apb(0, 12'h06c, 16'h1234);
		chk({err, q}, 17'h10000);
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		apb(0, A_CTRL, 0);
		chk(q, 16'hc000);
		apb(0, A_MASK, 0);
		chk(q, 0);
	endtask : t_soft

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			test_done;
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		t_reset;
		t_ctrl;
		t_irq;
		t_gate;
		t_soft;
		test_done;
	end
endmodule : tb_pei_ext_ctrl_irq
